// >>> spectral_threshold_pkg.sv
// package: register map, field layout and reset values of the threshold bank
package spectral_threshold_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int THR_W  = 16;
    localparam int PERS_W = 4;

    // ----------------------------------------------------------------
    // register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_LOW_LSB  = 8'h84;
    localparam logic [7:0] IDX_LOW_MSB  = 8'h85;
    localparam logic [7:0] IDX_HIGH_LSB = 8'h86;
    localparam logic [7:0] IDX_HIGH_MSB = 8'h87;
    localparam logic [7:0] IDX_STATUS   = 8'h93;
    localparam logic [7:0] IDX_PERSIST  = 8'hbd;
    localparam logic [7:0] IDX_ENABLE   = 8'hf9;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int FLAG_BIT = 3;
    localparam int EN_BIT   = 3;
    localparam logic [7:0]        THR_BYTE_RST = 8'h00;
    localparam logic [PERS_W-1:0] PERS_RST     = 4'h0;
    localparam logic              EN_RST       = 1'b0;

    typedef enum logic [1:0]
    {
        PH_IDLE = 2'b01,
        PH_RESP = 2'b10
    } apb_phase_t;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

endpackage

// >>> threshold_if.sv
// interface: byte writes and readback between bus slave and threshold pair
`timescale 1ns/1ps
interface threshold_if;
    logic        wrLsb;
    logic        wrMsb;
    logic [7:0]  wrData;
    logic [7:0]  lsbValue;
    logic [7:0]  msbValue;
    logic [15:0] active;

    modport ctrl
    (
        output wrLsb,
        output wrMsb,
        output wrData,
        input  lsbValue,
        input  msbValue,
        input  active
    );

    modport pair
    (
        input  wrLsb,
        input  wrMsb,
        input  wrData,
        output lsbValue,
        output msbValue,
        output active
    );
endinterface

// >>> threshold_pair.sv
// module: one 16-bit threshold built from a latched low byte and a high byte
`timescale 1ns/1ps
module threshold_pair
(
    input wire logic   sys_clk, // system clock
    input wire logic   reset,   // synchronous reset, active high
    threshold_if.pair  bus      // byte writes and threshold out
);
    typedef struct packed
    {
        logic [7:0]  lsb;
        logic [7:0]  msb;
        logic [15:0] active;
    } pair_state_t;

    localparam pair_state_t PAIR_RST = '{
        lsb:    spectral_threshold_pkg::THR_BYTE_RST,
        msb:    spectral_threshold_pkg::THR_BYTE_RST,
        active: {spectral_threshold_pkg::THR_BYTE_RST,
                 spectral_threshold_pkg::THR_BYTE_RST}
    };

    pair_state_t q;
    pair_state_t d;

    // ----------------------------------------------------------------
    // holding latch and atomic update
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        if (bus.wrLsb)
        begin
            d.lsb = bus.wrData;
        end
        if (bus.wrMsb)
        begin
            d.msb    = bus.wrData;
            // both halves land together, never a torn value
            d.active = {bus.wrData, q.lsb};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            q <= PAIR_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.lsbValue = q.lsb;
    assign bus.msbValue = q.msb;
    assign bus.active   = q.active;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_lsb_held;
        @(posedge sys_clk) disable iff (reset)
        (bus.wrLsb && !bus.wrMsb) |=> (bus.active == $past(bus.active));
    endproperty
    a_lsb_held: assert property (p_lsb_held)
        else $error("low byte write leaked into active threshold");

    property p_atomic;
        @(posedge sys_clk) disable iff (reset)
        bus.wrMsb |=> (bus.active == {$past(bus.wrData), $past(bus.lsbValue)});
    endproperty
    a_atomic: assert property (p_atomic)
        else $error("active threshold not formed from latch and high byte");
endmodule

// >>> persistence_filter.sv
// module: consecutive out-of-window counter that fires the spectral event
`timescale 1ns/1ps
module persistence_filter
#(
    parameter int CNT_W = 4                 // persistence field width
)
(
    input  wire logic             sys_clk,     // system clock
    input  wire logic             reset,       // synchronous reset
    input  wire logic             sampleValid, // new result captured
    input  wire logic             outside,     // result out of window
    input  wire logic             enable,      // interrupt enable
    input  wire logic [CNT_W-1:0] limit,       // consecutive count
    output logic                  eventPulse   // one-cycle event
);
    typedef struct packed
    {
        logic [CNT_W-1:0] cnt;
        logic             evt;
    } filt_state_t;

    filt_state_t q;
    filt_state_t d;
    logic [CNT_W-1:0] nextCnt;

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    always_comb
    begin
        d       = q;
        d.evt   = 1'b0;
        nextCnt = (&q.cnt) ? q.cnt : q.cnt + CNT_W'(1);
        if (sampleValid)
        begin
            if (outside)
            begin
                // saturate so a long excursion keeps firing
                d.cnt = nextCnt;
                d.evt = enable && (nextCnt >= limit);
            end
            else
            begin
                d.cnt = '0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign eventPulse = q.evt;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_inside_clears;
        @(posedge sys_clk) disable iff (reset)
        (sampleValid && !outside) |=> (q.cnt == '0) && !eventPulse;
    endproperty
    a_inside_clears: assert property (p_inside_clears)
        else $error("in-window sample did not restart persistence");

    property p_counts_up;
        @(posedge sys_clk) disable iff (reset)
        (sampleValid && outside && !(&q.cnt))
            |=> (q.cnt == $past(q.cnt) + CNT_W'(1));
    endproperty
    a_counts_up: assert property (p_counts_up)
        else $error("persistence count did not advance");
endmodule

// >>> spectral_threshold_interrupt.sv
// module: spectral threshold registers, window compare and status flag
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module spectral_threshold_interrupt
(
    input  wire logic        sys_clk,           // 200 MHz clock
    input  wire logic        reset,             // sync reset, high
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb enable
    input  wire logic        pwrite,            // apb direction
    input  wire logic [11:0] paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error
    input  wire logic        resultValid,       // channel 0 captured
    input  wire logic [15:0] channelZeroResult, // channel 0 value
    output logic             spectralIrq        // flag and enable
);
    // ----------------------------------------------------------------
    // decode positions
    // ----------------------------------------------------------------
    localparam int SEL_LOW_LSB  = 0;
    localparam int SEL_LOW_MSB  = 1;
    localparam int SEL_HIGH_LSB = 2;
    localparam int SEL_HIGH_MSB = 3;
    localparam int SEL_STATUS   = 4;
    localparam int SEL_PERSIST  = 5;
    localparam int SEL_ENABLE   = 6;
    localparam int SEL_N        = 7;

    typedef struct packed
    {
        spectral_threshold_pkg::apb_phase_t             phase;
        logic [31:0]                                    rdata;
        logic                                           ready;
        logic                                           slverr;
        logic [spectral_threshold_pkg::PERS_W-1:0]      pers;
        logic                                           enable;
        logic                                           flag;
        logic                                           irq;
    } top_state_t;

    localparam top_state_t TOP_RST = '{
        phase:  spectral_threshold_pkg::PH_IDLE,
        rdata:  32'h0000_0000,
        ready:  1'b0,
        slverr: 1'b0,
        pers:   spectral_threshold_pkg::PERS_RST,
        enable: spectral_threshold_pkg::EN_RST,
        flag:   1'b0,
        irq:    1'b0
    };

    top_state_t       q;
    top_state_t       d;
    logic [SEL_N-1:0] sel;
    logic             setupPhase;
    logic             accessDone;
    logic             wrEn;
    logic             flagClear;
    logic             belowLow;
    logic             aboveHigh;
    logic             eventPulse;
    logic [15:0]      lowThr;
    logic [15:0]      highThr;

    threshold_if thrBus[2] ();

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [SEL_N-1:0] decode(input logic [11:0] a);
        logic [SEL_N-1:0] s;
        s = '0;
        if (a == spectral_threshold_pkg::byte_addr(
                     spectral_threshold_pkg::IDX_LOW_LSB))
            s[SEL_LOW_LSB] = 1'b1;
        else if (a == spectral_threshold_pkg::byte_addr(
                     spectral_threshold_pkg::IDX_LOW_MSB))
            s[SEL_LOW_MSB] = 1'b1;
        else if (a == spectral_threshold_pkg::byte_addr(
                     spectral_threshold_pkg::IDX_HIGH_LSB))
            s[SEL_HIGH_LSB] = 1'b1;
        else if (a == spectral_threshold_pkg::byte_addr(
                     spectral_threshold_pkg::IDX_HIGH_MSB))
            s[SEL_HIGH_MSB] = 1'b1;
        else if (a == spectral_threshold_pkg::byte_addr(
                     spectral_threshold_pkg::IDX_STATUS))
            s[SEL_STATUS] = 1'b1;
        else if (a == spectral_threshold_pkg::byte_addr(
                     spectral_threshold_pkg::IDX_PERSIST))
            s[SEL_PERSIST] = 1'b1;
        else if (a == spectral_threshold_pkg::byte_addr(
                     spectral_threshold_pkg::IDX_ENABLE))
            s[SEL_ENABLE] = 1'b1;
        return s;
    endfunction

    assign sel        = decode(paddr);
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && q.ready;
    assign wrEn       = accessDone && pwrite;
    assign flagClear  = wrEn && sel[SEL_STATUS]
                        && pwdata[spectral_threshold_pkg::FLAG_BIT];

    // ----------------------------------------------------------------
    // threshold pairs: index 0 low, index 1 high
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_pair
            assign thrBus[i].wrData = pwdata[7:0];
            // each pair latches its low byte the same way
            assign thrBus[i].wrLsb  = wrEn && sel[2*i];
            assign thrBus[i].wrMsb  = wrEn && sel[2*i + 1];
            threshold_pair u_pair
            (
                .sys_clk (sys_clk),
                .reset   (reset),
                .bus     (thrBus[i])
            );
        end
    endgenerate

    assign lowThr  = thrBus[0].active;
    assign highThr = thrBus[1].active;

    // ----------------------------------------------------------------
    // window compare and persistence
    // ----------------------------------------------------------------
    // strict: a result equal to a threshold is still inside
    assign belowLow  = channelZeroResult < lowThr;
    assign aboveHigh = channelZeroResult > highThr;

    persistence_filter
    #(
        .CNT_W (spectral_threshold_pkg::PERS_W)
    )
    u_filter
    (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .sampleValid (resultValid),
        .outside     (belowLow || aboveHigh),
        .enable      (q.enable),
        .limit       (q.pers),
        .eventPulse  (eventPulse)
    );

    // ----------------------------------------------------------------
    // bus slave and control state
    // ----------------------------------------------------------------
    always_comb
    begin
        d        = q;
        d.ready  = 1'b0;
        d.slverr = 1'b0;
        case (q.phase)
            spectral_threshold_pkg::PH_IDLE:
            begin
                if (setupPhase)
                begin
                    // no wait state: read data is registered during the setup phase
                    d.phase  = spectral_threshold_pkg::PH_RESP;
                    d.ready  = 1'b1;
                    d.slverr = ~|sel;
                    d.rdata  = 32'h0000_0000;
                    if (sel[SEL_LOW_LSB])
                        d.rdata[7:0] = thrBus[0].lsbValue;
                    else if (sel[SEL_LOW_MSB])
                        d.rdata[7:0] = thrBus[0].msbValue;
                    else if (sel[SEL_HIGH_LSB])
                        d.rdata[7:0] = thrBus[1].lsbValue;
                    else if (sel[SEL_HIGH_MSB])
                        d.rdata[7:0] = thrBus[1].msbValue;
                    else if (sel[SEL_STATUS])
                        d.rdata[spectral_threshold_pkg::FLAG_BIT] = q.flag;
                    else if (sel[SEL_PERSIST])
                        d.rdata[spectral_threshold_pkg::PERS_W-1:0] = q.pers;
                    else if (sel[SEL_ENABLE])
                        d.rdata[spectral_threshold_pkg::EN_BIT] = q.enable;
                end
            end
            spectral_threshold_pkg::PH_RESP:
            begin
                d.phase = spectral_threshold_pkg::PH_IDLE;
            end
            default:
            begin
                d.phase = spectral_threshold_pkg::PH_IDLE;
            end
        endcase

        if (wrEn && sel[SEL_PERSIST])
        begin
            d.pers = pwdata[spectral_threshold_pkg::PERS_W-1:0];
        end
        if (wrEn && sel[SEL_ENABLE])
        begin
            d.enable = pwdata[spectral_threshold_pkg::EN_BIT];
        end

        // a new event beats a clear in the same cycle
        d.flag = (q.flag && !flagClear) || eventPulse;
        d.irq  = q.flag && q.enable;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            q <= TOP_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata      = q.rdata;
    assign pready      = q.ready;
    assign pslverr     = q.slverr;
    assign spectralIrq = q.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_event_seen;
        eventPulse;
    endsequence

    sequence s_flag_up;
        q.flag;
    endsequence

    property p_below_fires;
        @(posedge sys_clk) disable iff (reset)
        (resultValid && belowLow && q.enable && q.pers <= 4'h1)
            |=> s_event_seen ##1 s_flag_up;
    endproperty
    a_below_fires: assert property (p_below_fires)
        else $error("below-low sample did not set the flag");

    property p_above_fires;
        @(posedge sys_clk) disable iff (reset)
        (resultValid && aboveHigh && q.enable && q.pers <= 4'h1)
            |=> s_event_seen ##1 s_flag_up;
    endproperty
    a_above_fires: assert property (p_above_fires)
        else $error("above-high sample did not set the flag");

    property p_equal_inside;
        @(posedge sys_clk) disable iff (reset)
        // equal to either bound, other bound kept: still inside
        (resultValid
            && ((channelZeroResult == lowThr && channelZeroResult <= highThr)
             || (channelZeroResult == highThr && channelZeroResult >= lowThr)))
            |=> !eventPulse;
    endproperty
    a_equal_inside: assert property (p_equal_inside)
        else $error("result equal to threshold counted as outside");

    property p_needs_enable;
        @(posedge sys_clk) disable iff (reset)
        !q.enable |=> !eventPulse;
    endproperty
    a_needs_enable: assert property (p_needs_enable)
        else $error("event raised while interrupt disabled");

    property p_flag_cause;
        @(posedge sys_clk) disable iff (reset)
        $rose(q.flag) |-> $past(eventPulse);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("status flag set without an event");

    property p_one_clears;
        @(posedge sys_clk) disable iff (reset)
        (flagClear && !eventPulse) |=> !q.flag;
    endproperty
    a_one_clears: assert property (p_one_clears)
        else $error("write of one did not clear the flag");

    property p_zero_keeps;
        @(posedge sys_clk) disable iff (reset)
        (q.flag && !flagClear) |=> q.flag;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)
        else $error("flag lost without a write of one");

    property p_irq_follows;
        @(posedge sys_clk) disable iff (reset)
        (q.flag && q.enable) |=> spectralIrq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt output did not follow flag and enable");
endmodule

// >>> tb_top.sv
// testbench: register access, threshold latching and event flag checks
`timescale 1ns/1ps
module tb_top;

    // ----------------------------------------------------------------
    // signals and map
    // ----------------------------------------------------------------
    localparam logic [11:0] addrLowLsb  = 12'h210;
    localparam logic [11:0] addrLowMsb  = 12'h214;
    localparam logic [11:0] addrHighLsb = 12'h218;
    localparam logic [11:0] addrHighMsb = 12'h21c;
    localparam logic [11:0] addrStatus  = 12'h24c;
    localparam logic [11:0] addrPersist = 12'h2f4;
    localparam logic [11:0] addrEnable  = 12'h3e4;
    localparam logic [11:0] addrUnmap   = 12'h000;
    localparam int          cycleLimit  = 5000;

    logic        sys_clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        resultValid;
    logic [15:0] channelZeroResult;
    logic        spectralIrq;
    int          num_errors;
    int          checked;
    int          cycles;

    spectral_threshold_interrupt u_spectral_threshold_interrupt
    (
        .sys_clk           (sys_clk),
        .reset             (reset),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .resultValid       (resultValid),
        .channelZeroResult (channelZeroResult),
        .spectralIrq       (spectralIrq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // compare, bus and measurement tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic checkData(input logic [31:0] act, input logic [31:0] exp);
        checked++;
        if (act !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic checkFlag(input logic act, input logic exp);
        checked++;
        if (act !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, act, exp);
        end
    endtask

    // holds the request until pready is seen at a rising edge
    task automatic apbXfer(input logic wr, input logic [11:0] a,
                           input logic [31:0] d, output logic [31:0] rd,
                           output logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic regWrite(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apbXfer(1'b1, a, {24'h000000, d}, rd, err);
    endtask

    task automatic regRead(input logic [11:0] a, input logic [31:0] exp,
                           input logic expErr);
        logic [31:0] rd;
        logic        err;
        apbXfer(1'b0, a, 32'h00000000, rd, err);
        checkData(rd, exp);
        checkFlag(err, expErr);
    endtask

    // one measurement, then long enough for flag and irq to settle
    task automatic measure(input logic [15:0] v, input logic expIrq);
        @(posedge sys_clk);
        resultValid       <= 1'b1;
        channelZeroResult <= v;
        @(posedge sys_clk);
        resultValid       <= 1'b0;
        channelZeroResult <= ~v;
        repeat (4) @(posedge sys_clk);
        checkFlag(spectralIrq, expIrq);
    endtask

    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge sys_clk);
            cycles++;
            if (cycles >= cycleLimit)
            begin
                num_errors++;
                $display("ERROR t=%0t got %h expected %h", $time, cycles, 0);
                conclude();
            end
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [11:0] regs [7];
        regs = '{addrLowLsb, addrLowMsb, addrHighLsb, addrHighMsb,
                 addrStatus, addrPersist, addrEnable};
        num_errors = 0;
        checked = 0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        resultValid = 1'b0;
        channelZeroResult = 16'h0000;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (regs[i])
            regRead(regs[i], 32'h00000000, 1'b0);
        regRead(addrUnmap, 32'h00000000, 1'b1);
        regWrite(addrEnable, 8'h08);
        regWrite(addrPersist, 8'h01);
        regRead(addrEnable, 32'h00000008, 1'b0);
        regRead(addrPersist, 32'h00000001, 1'b0);
        regWrite(addrHighLsb, 8'hff);
        regWrite(addrHighMsb, 8'hff);
        regRead(addrHighMsb, 32'h000000ff, 1'b0);
        // low byte alone must leave the active low threshold at zero
        regWrite(addrLowLsb, 8'h34);
        regRead(addrLowLsb, 32'h00000034, 1'b0);
        measure(16'h0000, 1'b0);
        regWrite(addrLowMsb, 8'h12);
        measure(16'h1234, 1'b0);
        measure(16'h1233, 1'b1);
        regRead(addrStatus, 32'h00000008, 1'b0);
        regWrite(addrStatus, 8'h00);
        regRead(addrStatus, 32'h00000008, 1'b0);
        regWrite(addrStatus, 8'h08);
        regRead(addrStatus, 32'h00000000, 1'b0);
        checkFlag(spectralIrq, 1'b0);
        // high pair: latched low byte must not shrink the threshold
        regWrite(addrHighLsb, 8'h00);
        measure(16'hff01, 1'b0);
        regWrite(addrHighMsb, 8'h80);
        measure(16'h8000, 1'b0);
        measure(16'h8001, 1'b1);
        regWrite(addrStatus, 8'h08);
        // no event while the enable is off
        regWrite(addrEnable, 8'h00);
        measure(16'h0000, 1'b0);
        regRead(addrStatus, 32'h00000000, 1'b0);
        regWrite(addrEnable, 8'h08);
        // three in a row needed; an inside sample restarts the count
        // counter kept tracking while disabled, so restart it first
        regWrite(addrPersist, 8'h03);
        measure(16'h5000, 1'b0);
        measure(16'h0000, 1'b0);
        measure(16'h0000, 1'b0);
        measure(16'h5000, 1'b0);
        measure(16'h0000, 1'b0);
        measure(16'h0000, 1'b0);
        measure(16'h0000, 1'b1);
        regRead(addrStatus, 32'h00000008, 1'b0);
        conclude();
    end

endmodule
